// ---- hdl/amc_map.svh ----
// Constants of the serial converter control block.
// Assumes a 40 MHz system clock; included by the package and modules.
//
// Behaviour
// - Five address bits arrive in order: powerup, mode, odd/sign, select high, select low.
// - Powerup field zero powers down and disconnects all channels, ignoring other fields.
// - First conversion after power-on is invalid; host discards it.
// - High chip select after conversion holds result until chip select returns low.
// - Hardware powerdown input high keeps the device powered down regardless of address.
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH
`define AMC_ADDR_BITS      5
`define AMC_POS_PU         4
`define AMC_POS_MODE       3
`define AMC_POS_SIGN       2
`define AMC_POS_SELHI      1
`define AMC_POS_SELLO      0
`define AMC_RESULT_BITS    11
`define AMC_CONV_CYCLES    8'd13
`define AMC_TPC_NS         10000
`define AMC_CLK_NS         25
`define AMC_TPC_CYCLES     ((`AMC_TPC_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
`define AMC_CHAN_RESET     8'h00
`endif

// ---- hdl/amc_pkg.sv ----
// Types of the serial converter control block.
// Assumes amc_map.svh is on the include path.
`include "amc_map.svh"
package amc_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ADDR  = 4'b0010,
      ST_CONV  = 4'b0100,
      ST_SHIFT = 4'b1000
   } amc_state_t;
endpackage

// ---- hdl/amc_mux_decode.sv ----
// Multiplexer address decoder.
// Assumes a latched five-bit address and a powerdown level.
`timescale 1ns/100ps
`include "amc_map.svh"
module amc_mux_decode
#(
   parameter int NCH = 8
)
(
   input  wire logic [`AMC_ADDR_BITS-1:0] addr,
   input  wire logic                      forceDown,
   output logic      [NCH-1:0]            chanPos,
   output logic      [NCH-1:0]            chanNeg,
   output logic                           comNeg,
   output logic                           powered
);
   logic [2:0] posIdx;
   logic [2:0] negIdx;
   logic       live;
   always_comb
   begin
      live   = addr[`AMC_POS_PU] & ~forceDown;
      posIdx = {addr[`AMC_POS_SELHI], addr[`AMC_POS_SELLO], addr[`AMC_POS_SIGN]};
      negIdx = {addr[`AMC_POS_SELHI], addr[`AMC_POS_SELLO], ~addr[`AMC_POS_SIGN]};
   end
   genvar i;
   generate
      for (i = 0; i < NCH; i++)
      begin : g_ch
         assign chanPos[i] = live && (posIdx == 3'(i));
         assign chanNeg[i] = live && !addr[`AMC_POS_MODE] && (negIdx == 3'(i));
      end
   endgenerate
   assign comNeg  = live & addr[`AMC_POS_MODE];
   assign powered = live;
endmodule // amc_mux_decode

// ---- hdl/amc_serial_ctrl.sv ----
// Serial control of a successive-approximation converter.
// Assumes host pins synchronous to clk_sys and sampled on serial clock enable pulses.
`timescale 1ns/100ps
`include "amc_map.svh"
module amc_serial_ctrl
   import amc_pkg::*;
#(
   parameter int NCH        = 8,
   parameter int TPC_CYCLES = `AMC_TPC_CYCLES
)
(
   input  wire logic                        clk_sys,
   input  wire logic                        arst_n,
   input  wire logic                        csN,
   input  wire logic                        sclkRise,
   input  wire logic                        sclkFall,
   input  wire logic                        serial_in,
   input  wire logic                        hw_powerdown_in,
   input  wire logic [`AMC_RESULT_BITS-1:0] convResult,
   output logic                             serialOut,
   output logic                             serialOutEn,
   output logic                             conversion_active_flag,
   output logic                             resultValid,
   output logic                             recoveryDone,
   output logic      [NCH-1:0]              chanPos,
   output logic      [NCH-1:0]              chanNeg,
   output logic                             comNeg,
   output logic                             analogPowered
);
   import amc_pkg::*;
   // ----------------------------------------------------------------
   // State and registers.
   // ----------------------------------------------------------------
   amc_state_t                       state_q;
   logic [`AMC_ADDR_BITS-1:0]        addrShift_q;
   logic [`AMC_ADDR_BITS-1:0]        addr_q;
   logic [2:0]                       bitCnt_q;
   logic [7:0]                       cnt_q;
   logic [`AMC_RESULT_BITS-1:0]      result_q;
   logic                             firstDone_q;
   logic                             csHighSeen_q;
   logic [15:0]                      rec_q;
   logic                             serialOut_q;
   // ----------------------------------------------------------------
   // Conversion sequence.
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q     <= ST_IDLE;
         addrShift_q <= '0;
         addr_q      <= '0;
         bitCnt_q    <= '0;
         cnt_q       <= `AMC_CHAN_RESET;
         result_q    <= '0;
      end
      else if (csN && state_q != ST_CONV && state_q != ST_SHIFT)
      begin
         state_q  <= ST_IDLE;
         bitCnt_q <= '0;
      end
      else if (csN && state_q == ST_SHIFT && cnt_q == 8'd0)
      begin
         state_q <= ST_IDLE;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (!csN && csHighSeen_q)
               begin
                  state_q  <= ST_ADDR;
                  bitCnt_q <= '0;
               end
            end
            ST_ADDR:
            begin
               if (sclkRise)
               begin
                  addrShift_q <= {addrShift_q[`AMC_ADDR_BITS-2:0], serial_in};
                  bitCnt_q    <= bitCnt_q + 3'd1;
                  if (bitCnt_q == 3'(`AMC_ADDR_BITS - 1))
                  begin
                     addr_q  <= {addrShift_q[`AMC_ADDR_BITS-2:0], serial_in};
                     state_q <= ST_CONV;
                     cnt_q   <= `AMC_CONV_CYCLES;
                  end
               end
            end
            ST_CONV:
            begin
               if (sclkRise)
               begin
                  cnt_q <= cnt_q - 8'd1;
                  if (cnt_q == 8'd1)
                  begin
                     result_q <= convResult;
                     state_q  <= ST_SHIFT;
                     cnt_q    <= 8'(`AMC_RESULT_BITS);
                  end
               end
            end
            ST_SHIFT:
            begin
               if (!csN && sclkFall && cnt_q != 8'd0)
               begin
                  cnt_q <= cnt_q - 8'd1;
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Power-on and recovery tracking.
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         csHighSeen_q <= 1'b0;
         firstDone_q  <= 1'b0;
      end
      else
      begin
         if (csN)
         begin
            csHighSeen_q <= 1'b1;
         end
         if (state_q == ST_SHIFT && csN && cnt_q == 8'd0)
         begin
            firstDone_q <= 1'b1;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rec_q <= '0;
      end
      else if (hw_powerdown_in)
      begin
         rec_q <= '0;
      end
      else if (csN && rec_q != 16'(TPC_CYCLES))
      begin
         rec_q <= rec_q + 16'd1;
      end
   end
   assign recoveryDone = (rec_q == 16'(TPC_CYCLES));
   // ----------------------------------------------------------------
   // Output shifter.
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         serialOut_q <= 1'b0;
      end
      else if (state_q == ST_SHIFT && !csN && cnt_q != 8'd0)
      begin
         serialOut_q <= result_q[cnt_q[3:0] - 4'd1];
      end
   end
   assign serialOut              = serialOut_q;
   assign serialOutEn            = !csN && state_q == ST_SHIFT;
   assign conversion_active_flag = (state_q == ST_CONV);
   assign resultValid            = firstDone_q && state_q == ST_SHIFT;
   amc_mux_decode #(.NCH(NCH)) u_dec
   (
      .addr      (addr_q),
      .forceDown (hw_powerdown_in),
      .chanPos   (chanPos),
      .chanNeg   (chanNeg),
      .comNeg    (comNeg),
      .powered   (analogPowered)
   );
   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   property p_hwpd;
      @(posedge clk_sys) disable iff (!arst_n) hw_powerdown_in |-> !analogPowered;
   endproperty
   a_hwpd: assert property (p_hwpd) else $error("Powered while hardware powerdown.");
   property p_pu0;
      @(posedge clk_sys) disable iff (!arst_n)
         !addr_q[`AMC_POS_PU] |-> (chanPos == '0 && chanNeg == '0 && !comNeg);
   endproperty
   a_pu0: assert property (p_pu0) else $error("Channel connected in powerdown.");
   property p_se;
      @(posedge clk_sys) disable iff (!arst_n)
         analogPowered && addr_q[`AMC_POS_MODE] |-> comNeg && chanNeg == '0;
   endproperty
   a_se: assert property (p_se) else $error("Single-ended negative wrong.");
   property p_hold;
      @(posedge clk_sys) disable iff (!arst_n)
         state_q == ST_SHIFT && csN && cnt_q != 8'd0 |=> state_q == ST_SHIFT && $stable(cnt_q);
   endproperty
   a_hold: assert property (p_hold) else $error("Result lost while delayed.");
   property p_reset;
      @(posedge clk_sys) disable iff (!arst_n)
         csN && state_q == ST_ADDR |=> state_q == ST_IDLE;
   endproperty
   a_reset: assert property (p_reset) else $error("High chip select did not reset.");
   property p_first;
      @(posedge clk_sys) disable iff (!arst_n) !firstDone_q |-> !resultValid;
   endproperty
   a_first: assert property (p_first) else $error("First result marked valid.");
   property p_load;
      @(posedge clk_sys) disable iff (!arst_n)
         state_q == ST_ADDR && sclkRise && bitCnt_q == 3'd4 && !csN
         |=> addr_q[0] == $past(serial_in) && state_q == ST_CONV;
   endproperty
   a_load: assert property (p_load) else $error("Address not latched.");
   property p_rec;
      @(posedge clk_sys) disable iff (!arst_n) hw_powerdown_in |=> !recoveryDone;
   endproperty
   a_rec: assert property (p_rec) else $error("Recovery done too early.");
   property p_start;
      @(posedge clk_sys) disable iff (!arst_n)
         !csHighSeen_q |-> state_q == ST_IDLE;
   endproperty
   a_start: assert property (p_start) else $error("Started before chip select high.");
   c_conv: cover property (@(posedge clk_sys) state_q == ST_CONV ##1 state_q == ST_SHIFT);
   c_delay: cover property (@(posedge clk_sys) state_q == ST_SHIFT && csN);
   c_diff: cover property (@(posedge clk_sys) analogPowered && !comNeg);
endmodule // amc_serial_ctrl

// ---- dv/amc_host_model.sv ----
// Host model of the serial port: chip select, serial clock pulses, address data.
// Assumes clk_sys is the block clock and the bench calls the tasks in order.
`timescale 1ns/100ps
module amc_host_model
(
   input  wire logic clk_sys,
   output logic      csN,
   output logic      sclkRise,
   output logic      sclkFall,
   output logic      serial_in
);
   // --------------------
   // Serial port drive
   // --------------------
   initial
   begin
      csN       = 1'h1;
      sclkRise  = 1'h0;
      sclkFall  = 1'h0;
      serial_in = 1'h0;
   end
   // Chip select level, changed at a clock edge.
   task automatic sel(input logic lvl);
      @(posedge clk_sys);
      csN <= lvl;
   endtask
   // Rise pulse; an undriven data line shows the inverse of its last value.
   task automatic rise(input logic b, input logic drive);
      @(posedge clk_sys);
      sclkRise  <= 1'h1;
      serial_in <= drive ? b : ~serial_in;
      @(posedge clk_sys);
      sclkRise  <= 1'h0;
   endtask
   task automatic fall();
      @(posedge clk_sys);
      sclkFall  <= 1'h1;
      serial_in <= ~serial_in;
      @(posedge clk_sys);
      sclkFall  <= 1'h0;
   endtask
   // Address word, power-up field first, cut short after nbits.
   task automatic addr(input logic [4:0] a, input int nbits);
      for (int i = 4; i > 4 - nbits; i--)
      begin
         rise(a[i], 1'h1);
         fall();
      end
   endtask
endmodule // amc_host_model

// ---- dv/amc_serial_ctrl_tb.sv ----
// Self-checking bench of the serial converter control block.
// Assumes the host model drives the serial port; the bench drives the rest.
`timescale 1ns/100ps
module amc_serial_ctrl_tb;
   import amc_pkg::*;
   // --------------------
   // Signals and instances
   // --------------------
   logic        clk_sys;
   logic        arst_n;
   logic        hwPd;
   logic [10:0] convRes;
   logic        csN, sclkRise, sclkFall, serialIn;
   logic        serialOut, serialOutEn, convFlag, resultValid, recoveryDone;
   logic [7:0]  chanPos, chanNeg;
   logic        comNeg, analogPowered;
   int          num_errors = 0;
   int          checked = 0;
   logic        validExp = 1'h0;

   amc_serial_ctrl #(.NCH(8), .TPC_CYCLES(5)) DUT
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .csN(csN), .sclkRise(sclkRise),
      .sclkFall(sclkFall), .serial_in(serialIn), .hw_powerdown_in(hwPd),
      .convResult(convRes), .serialOut(serialOut), .serialOutEn(serialOutEn),
      .conversion_active_flag(convFlag), .resultValid(resultValid),
      .recoveryDone(recoveryDone), .chanPos(chanPos), .chanNeg(chanNeg),
      .comNeg(comNeg), .analogPowered(analogPowered)
   );
   amc_host_model host
   (
      .clk_sys(clk_sys), .csN(csN), .sclkRise(sclkRise), .sclkFall(sclkFall),
      .serial_in(serialIn)
   );
   // --------------------
   // Checking tasks
   // --------------------
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic settle();
      @(posedge clk_sys);
      #1;
   endtask
   // Expected {powered, common negative, positive, negative} for an address.
   function automatic logic [17:0] exp_dec(input logic [4:0] a, input logic pd);
      logic [2:0] ix;
      logic [7:0] p, n;
      ix = {a[1], a[0], a[2]};
      p = 8'h00;
      n = 8'h00;
      if (a[4] && !pd)
      begin
         p[ix] = 1'h1;
         if (!a[3])
            n[ix ^ 3'h1] = 1'h1;
      end
      return {a[4] && !pd, a[4] && !pd && a[3], p, n};
   endfunction
   // One conversion frame; keep selects whether the result is compared.
   task automatic frame(input logic [4:0] a, input logic pd, input int hold, input logic keep);
      logic [10:0] r;
      r = 11'($urandom);
      @(posedge clk_sys);
      convRes <= r;
      hwPd    <= pd;
      host.sel(1'h0);
      host.addr(a, 5);
      settle();
      check("decode", {analogPowered, comNeg, chanPos, chanNeg}, exp_dec(a, pd));
      if (keep)
         check("busy", convFlag, 1'h1);
      for (int i = 0; i < 13; i++)
      begin
         host.rise(1'($urandom), 1'h1);
         if (i < 12)
            host.fall();
      end
      if (hold > 0)
      begin
         settle();
         host.sel(1'h1);
         repeat (hold) settle();
         check("held enable", serialOutEn, 1'h0);
         host.sel(1'h0);
      end
      for (int k = 10; k >= 0; k--)
      begin
         settle();
         if (keep)
            check("data", serialOut, r[k]);
         if (k == 10)
            check("enable", {serialOutEn, resultValid}, {1'h1, validExp});
         host.fall();
         if (k > 0)
            host.rise(1'h0, 1'h0);
      end
      host.sel(1'h1);
      settle();
      validExp = 1'h1;
   endtask
   // --------------------
   // Clock, watchdog and main sequence
   // --------------------
   initial
   begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      num_errors++;
      final_report();
   end
   initial
   begin
      logic [4:0] sh;
      logic [4:0] a;
      logic       pd;
      arst_n  = 1'h0;
      hwPd    = 1'h0;
      convRes = 11'h000;
      void'($urandom(32'he6cf));
      sh = 5'($urandom);
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'h1;
      repeat (2) settle();
      frame(5'h18, 1'h0, 0, 1'h0);
      for (int i = 0; i < 32; i++)
      begin
         a = 5'(i) ^ sh;
         pd = 1'($urandom);
         frame(a, pd, $urandom % 4, a[4]);
         if (pd)
         begin
            @(posedge clk_sys);
            hwPd <= 1'h0;
            repeat (6) settle();
            check("recovery", recoveryDone, 1'h1);
         end
      end
      a = 5'h1d;
      frame(a, 1'h0, 0, 1'h1);
      host.sel(1'h0);
      host.addr(~a, 3);
      host.sel(1'h1);
      repeat (2) settle();
      check("aborted", {analogPowered, comNeg, chanPos, chanNeg}, exp_dec(a, 1'h0));
      frame(~a, 1'h0, 8, 1'h1);
      @(posedge clk_sys);
      hwPd <= 1'h1;
      frame(5'h1f, 1'h1, 0, 1'h0);
      @(posedge clk_sys);
      hwPd <= 1'h0;
      repeat (2) settle();
      check("recovery early", recoveryDone, 1'h0);
      repeat (6) settle();
      check("recovery", recoveryDone, 1'h1);
      frame(5'h17, 1'h0, 1, 1'h1);
      final_report();
   end
endmodule // amc_serial_ctrl_tb
